// *** rtl/spiwk_cfg.svh ***
`ifndef SPIWK_CFG_SVH
`define SPIWK_CFG_SVH
// **********************************************
// configuration bit positions
// **********************************************
`define SPIWK_CFG_ENABLE_BIT   0
`define SPIWK_CFG_MASTER_BIT   2
`define SPIWK_CFG_PHASE_BIT    4
`define SPIWK_CFG_POL_BIT      5
`define SPIWK_CFG_WIDTH        6
// **********************************************
// status / enable bit positions
// **********************************************
`define SPIWK_EV_RXRDY_BIT     0
`define SPIWK_EV_OVERRUN_BIT   1
`define SPIWK_EV_SELCHG_BIT    2
`define SPIWK_EV_WIDTH         3
// **********************************************
// reset values and timing
// **********************************************
`define SPIWK_SEL_POL_RESET    4'h0
`define SPIWK_FRAME_BITS       8
`define SPIWK_HALF_PERIOD      4
`define SPIWK_SEL_COUNT        4
`endif

// *** rtl/spiwk_pkg.sv ***
package spiwk_pkg;
  typedef enum logic [4:0] {
    SPIWK_IDLE  = 5'h01,
    SPIWK_SETUP = 5'h02,
    SPIWK_LEAD  = 5'h04,
    SPIWK_TRAIL = 5'h08,
    SPIWK_HOLD  = 5'h10
  } spiwk_mst_e;
endpackage

// *** rtl/spiwk_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module spiwk_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  // first stage is read only by the second stage
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// *** rtl/spiwk_top.sv ***
`include "spiwk_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module spiwk_top
  import spiwk_pkg::*;
#(
  parameter int FRAME_BITS  = `SPIWK_FRAME_BITS,
  parameter int HALF_PERIOD = `SPIWK_HALF_PERIOD,
  parameter int SEL_COUNT   = `SPIWK_SEL_COUNT
) (
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_b_in,
  input  wire logic                      port_enable_in,
  input  wire logic                      role_master_in,
  input  wire logic                      clock_capture_phase_select_in,
  input  wire logic                      clock_rest_level_select_in,
  input  wire logic [SEL_COUNT-1:0]      sel_active_high_in,
  input  wire logic [SEL_COUNT-1:0]      sel_target_in,
  input  wire logic [`SPIWK_EV_WIDTH-1:0] int_enable_set_in,
  input  wire logic [`SPIWK_EV_WIDTH-1:0] int_enable_clr_in,
  input  wire logic [`SPIWK_EV_WIDTH-1:0] status_clr_in,
  input  wire logic                      tx_valid_in,
  input  wire logic [FRAME_BITS-1:0]     tx_data_in,
  input  wire logic                      rx_read_in,
  input  wire logic                      sck_in,
  input  wire logic                      mosi_in,
  input  wire logic                      miso_in,
  input  wire logic [SEL_COUNT-1:0]      sel_in,
  output logic                           sck_out,
  output logic                           sck_oe_b_out,
  output logic                           mosi_out,
  output logic                           mosi_oe_b_out,
  output logic                           miso_out,
  output logic                           miso_oe_b_out,
  output logic [SEL_COUNT-1:0]           sel_out,
  output logic [SEL_COUNT-1:0]           sel_oe_b_out,
  output logic                           tx_ready_out,
  output logic                           rx_valid_out,
  output logic [FRAME_BITS-1:0]          rx_data_out,
  output logic [`SPIWK_EV_WIDTH-1:0]     status_out,
  output logic [`SPIWK_EV_WIDTH-1:0]     interrupt_enable_set_reg_out,
  output logic                           wake_out
);
  localparam int CW = $clog2(FRAME_BITS + 1);
  localparam int HW = $clog2(HALF_PERIOD + 1);

  // **********************************************
  // helpers
  // **********************************************
  function automatic logic [SEL_COUNT-1:0] sel_to_pin(
    input logic [SEL_COUNT-1:0] act,
    input logic [SEL_COUNT-1:0] pol
  );
    // active low by default: pin = ~active unless polarity high
    sel_to_pin = act ~^ pol;
  endfunction

  // **********************************************
  // pin synchronisers
  // **********************************************
  logic                 sck_s;
  logic                 mosi_s;
  logic                 miso_s;
  logic [SEL_COUNT-1:0] sel_s;

  spiwk_sync #(.WIDTH(SEL_COUNT + 3)) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .async_in   ({sck_in, mosi_in, miso_in, sel_in}),
    .sync_out   ({sck_s, mosi_s, miso_s, sel_s})
  );

  logic                 en;
  logic                 mst;
  logic                 slv_run;
  logic                 sel_any;
  logic [SEL_COUNT-1:0] sel_act;
  assign en      = port_enable_in;
  assign mst     = role_master_in;
  // any select at its active level addresses the slave
  assign sel_act = sel_s ~^ sel_active_high_in;
  assign sel_any = |sel_act;
  assign slv_run = en && !mst && sel_any;

  // **********************************************
  // master engine
  // **********************************************
  spiwk_mst_e          state_reg;
  logic [CW-1:0]       mbit_reg;
  logic [HW-1:0]       half_reg;
  logic [FRAME_BITS-1:0] mtx_reg;
  logic [FRAME_BITS-1:0] mrx_reg;
  logic                sck_lvl_reg;
  logic                msel_reg;
  logic                mdone_reg;
  logic                half_hit;
  assign half_hit = (half_reg == HW'(HALF_PERIOD - 1));

  // disabled or slave: engine held idle, counters and flags cleared, shift data kept
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg   <= SPIWK_IDLE;
      mbit_reg    <= '0;
      half_reg    <= '0;
      mtx_reg     <= '0;
      mrx_reg     <= '0;
      sck_lvl_reg <= 1'b0;
      msel_reg    <= 1'b0;
      mdone_reg   <= 1'b0;
    end else if (!en || !mst) begin
      state_reg   <= SPIWK_IDLE;
      mbit_reg    <= '0;
      half_reg    <= '0;
      sck_lvl_reg <= 1'b0;
      msel_reg    <= 1'b0;
      mdone_reg   <= 1'b0;
    end else begin
      mdone_reg <= 1'b0;
      half_reg  <= half_hit ? '0 : half_reg + HW'(1);
      case (state_reg)
        SPIWK_IDLE: begin
          half_reg <= '0;
          if (tx_valid_in) begin
            mtx_reg   <= tx_data_in;
            mbit_reg  <= '0;
            msel_reg  <= 1'b1; // select before first bit
            state_reg <= SPIWK_SETUP;
          end
        end
        SPIWK_SETUP: begin
          if (half_hit) begin
            sck_lvl_reg <= 1'b1; // leading edge
            if (!clock_capture_phase_select_in)
              mrx_reg <= {mrx_reg[FRAME_BITS-2:0], miso_s};
            state_reg <= SPIWK_LEAD;
          end
        end
        SPIWK_LEAD: begin
          if (half_hit) begin
            sck_lvl_reg <= 1'b0;
            mbit_reg    <= mbit_reg + CW'(1);
            if (clock_capture_phase_select_in)
              mrx_reg <= {mrx_reg[FRAME_BITS-2:0], miso_s};
            else
              mtx_reg <= {mtx_reg[FRAME_BITS-2:0], 1'b0};
            if (mbit_reg == CW'(FRAME_BITS - 1))
              state_reg <= SPIWK_HOLD;
            else
              state_reg <= SPIWK_TRAIL;
          end
        end
        SPIWK_TRAIL: begin
          if (half_hit) begin
            sck_lvl_reg <= 1'b1;
            if (clock_capture_phase_select_in)
              mtx_reg <= {mtx_reg[FRAME_BITS-2:0], 1'b0};
            else
              mrx_reg <= {mrx_reg[FRAME_BITS-2:0], miso_s};
            state_reg <= SPIWK_LEAD;
          end
        end
        SPIWK_HOLD: begin
          if (half_hit) begin
            msel_reg  <= 1'b0; // release after last bit
            mdone_reg <= 1'b1;
            state_reg <= SPIWK_IDLE;
          end
        end
        default: state_reg <= SPIWK_IDLE;
      endcase
    end
  end

  // **********************************************
  // slave engine, edges found on synchronised clock
  // **********************************************
  logic                  sck_d_reg;
  logic [CW-1:0]         sbit_reg;
  logic [FRAME_BITS-1:0] stx_reg;
  logic [FRAME_BITS-1:0] srx_reg;
  logic                  sdone_reg;
  logic                  s_lead;
  logic                  s_trail;
  logic                  s_edge;
  logic                  s_cap;
  assign s_edge  = sck_s != sck_d_reg;
  // leading edge leaves the rest level
  assign s_lead  = s_edge && (sck_d_reg == clock_rest_level_select_in);
  assign s_trail = s_edge && !s_lead;
  assign s_cap   = clock_capture_phase_select_in ? s_trail : s_lead;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sck_d_reg <= 1'b0;
      sbit_reg  <= '0;
      stx_reg   <= '0;
      srx_reg   <= '0;
      sdone_reg <= 1'b0;
    end else begin
      sck_d_reg <= sck_s;
      sdone_reg <= 1'b0;
      if (!slv_run) begin
        sbit_reg <= '0;
        stx_reg  <= tx_data_in;
      end else if (s_cap) begin
        srx_reg <= {srx_reg[FRAME_BITS-2:0], mosi_s};
        if (sbit_reg == CW'(FRAME_BITS - 1)) begin
          sbit_reg  <= '0;
          sdone_reg <= 1'b1;
        end else begin
          sbit_reg <= sbit_reg + CW'(1);
        end
      end else if (s_edge &&
                   !(clock_capture_phase_select_in && sbit_reg == '0)) begin
        // first leading edge keeps the msb already on the pin
        stx_reg <= {stx_reg[FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  // **********************************************
  // pin drive, enables low while driving
  // **********************************************
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sck_out       <= 1'b0;
      sck_oe_b_out  <= 1'b1;
      mosi_out      <= 1'b0;
      mosi_oe_b_out <= 1'b1;
      miso_out      <= 1'b0;
      miso_oe_b_out <= 1'b1;
      sel_out       <= ~`SPIWK_SEL_POL_RESET;
      sel_oe_b_out  <= '1;
    end else begin
      // rest level xor toggle only inside a frame
      sck_out       <= clock_rest_level_select_in ^ sck_lvl_reg;
      sck_oe_b_out  <= !mst;
      mosi_out      <= mtx_reg[FRAME_BITS-1];
      mosi_oe_b_out <= !mst;
      miso_out      <= stx_reg[FRAME_BITS-1];
      miso_oe_b_out <= !slv_run;
      sel_out       <= sel_to_pin(sel_target_in & {SEL_COUNT{msel_reg}},
                                  sel_active_high_in);
      sel_oe_b_out  <= {SEL_COUNT{!mst}};
    end
  end

  // **********************************************
  // data handoff
  // **********************************************
  logic [`SPIWK_EV_WIDTH-1:0] ev;
  logic                       frame_done;
  logic                       sel_any_d_reg;
  assign frame_done = mdone_reg || sdone_reg;
  assign ev[`SPIWK_EV_RXRDY_BIT]   = frame_done;
  assign ev[`SPIWK_EV_OVERRUN_BIT] = frame_done && rx_valid_out && !rx_read_in;
  assign ev[`SPIWK_EV_SELCHG_BIT]  = en && !mst && (sel_any != sel_any_d_reg);

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_valid_out  <= 1'b0;
      rx_data_out   <= '0;
      tx_ready_out  <= 1'b0;
      sel_any_d_reg <= 1'b0;
    end else begin
      sel_any_d_reg <= sel_any;
      tx_ready_out  <= en && mst && (state_reg == SPIWK_IDLE);
      // overrun keeps the older word; new frame lost
      if (frame_done && !(rx_valid_out && !rx_read_in)) begin
        rx_valid_out <= 1'b1;
        // last bit already shifted in when the done flag rises
        rx_data_out  <= mst ? mrx_reg : srx_reg;
      end else if (rx_read_in) begin
        rx_valid_out <= 1'b0;
      end
    end
  end

  // **********************************************
  // status, enables and wake
  // **********************************************
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status_out                   <= '0;
      interrupt_enable_set_reg_out <= '0;
      wake_out                     <= 1'b0;
    end else begin
      // set wins over clear
      status_out <= (status_out & ~status_clr_in) | ev;
      interrupt_enable_set_reg_out <=
        (interrupt_enable_set_reg_out & ~int_enable_clr_in)
        | int_enable_set_in;
      // works in both roles; deep sleep needs master clock
      wake_out <= |(status_out & interrupt_enable_set_reg_out);
    end
  end

  // **********************************************
  // checks
  // **********************************************
  property p_sck_rest;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (state_reg == SPIWK_IDLE) |=> (sck_out == $past(clock_rest_level_select_in));
  endproperty
  a_sck_rest: assert property (p_sck_rest) else $error("clock not at rest");

  property p_sck_drive;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      mst |=> !sck_oe_b_out && !mosi_oe_b_out && (sel_oe_b_out == '0);
  endproperty
  a_sck_drive: assert property (p_sck_drive) else $error("master not driving");

  property p_miso_drive;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      !miso_oe_b_out |-> $past(en) && !$past(mst) && $past(sel_any);
  endproperty
  a_miso_drive: assert property (p_miso_drive) else $error("miso driven wrongly");

  property p_sel_first;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (state_reg == SPIWK_SETUP) |-> msel_reg;
  endproperty
  a_sel_first: assert property (p_sel_first) else $error("select late");

  property p_sel_release;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      mdone_reg |-> !msel_reg ##1 (state_reg == SPIWK_IDLE) || tx_valid_in;
  endproperty
  a_sel_release: assert property (p_sel_release) else $error("select held");

  property p_disable_hold;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      !en |=> (state_reg == SPIWK_IDLE) && (mbit_reg == '0) && (sbit_reg == '0);
  endproperty
  a_disable_hold: assert property (p_disable_hold) else $error("not held");

  property p_wake;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (|(status_out & interrupt_enable_set_reg_out)) |=> wake_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missing");

  property p_rx_event;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      frame_done |=> status_out[`SPIWK_EV_RXRDY_BIT];
  endproperty
  a_rx_event: assert property (p_rx_event) else $error("rx event lost");

  property p_reset_sel;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (sel_active_high_in == '0) && !msel_reg |=> (sel_out == '1);
  endproperty
  a_reset_sel: assert property (p_reset_sel) else $error("select not low-act");
endmodule
`default_nettype wire

// *** bench/spiwk_far_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************
// far-side spi party
// ****************
module spiwk_far_model (
  input  wire logic       master_in,
  input  wire logic       pol_in,
  input  wire logic       pha_in,
  input  wire logic [7:0] reply_in,
  input  wire logic       sck_in,
  input  wire logic       mosi_in,
  input  wire logic       miso_in,
  input  wire logic       sel_in,
  output logic            sck_out,
  output logic            mosi_out,
  output logic            miso_out,
  output logic            sel_out,
  output logic [7:0]      got_out
);
  int idx = 7;
  initial begin
    sck_out  = 1'b0;
    mosi_out = 1'b0;
    miso_out = 1'b0;
    sel_out  = 1'b1;
    got_out  = 8'h00;
  end
  // slave role: msb ready at select when capture comes first
  always @(negedge sel_in) if (!master_in) begin
    idx = pha_in ? 7 : 6;
    if (!pha_in) miso_out = reply_in[7];
  end
  // released line has no pull, so it must not keep the last bit
  always @(posedge sel_in) if (!master_in) miso_out = ~miso_out;
  always @(sck_in) if (!master_in && !sel_in) begin
    if ((sck_in != pol_in) ^ pha_in) got_out = {got_out[6:0], mosi_in};
    else if (idx >= 0) begin
      miso_out = reply_in[idx];
      idx--;
    end
  end
  // master role: clock stands at rest outside the frame
  task automatic master_frame();
    int i;
    sck_out = pol_in;
    #80;
    sel_out = 1'b0;
    if (!pha_in) mosi_out = reply_in[7];
    #80;
    for (i = 7; i >= 0; i--) begin
      sck_out = ~pol_in;
      if (pha_in) mosi_out = reply_in[i];
      else got_out = {got_out[6:0], miso_in};
      #80;
      sck_out = pol_in;
      if (pha_in) got_out = {got_out[6:0], miso_in};
      else if (i > 0) mosi_out = reply_in[i-1];
      #80;
    end
    sel_out  = 1'b1;
    mosi_out = ~mosi_out;
  endtask
endmodule
`default_nettype wire

// *** bench/spi_pin_control_wakeup_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin \
  compares++; \
  if ((a) !== (b)) begin \
    mismatches++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); \
  end \
end
// ****************
// bench top
// ****************
module spi_pin_control_wakeup_tb_top;
  typedef struct packed {
    logic       m, p, h;
    logic [7:0] tx, ftx;
  } spiwk_row_s;
  logic       clk = 1'b0, rst_b = 1'b0, en = 1'b1, mst = 1'b1;
  logic       pha = 1'b0, pol = 1'b0, tx_valid = 1'b0, rx_read = 1'b0;
  logic [3:0] sel_hi = 4'h0, sel_o, sel_oeb, sel_w;
  logic [2:0] ie_set = 3'h0, ie_clr = 3'h0, st_clr = 3'h0, status, ie_reg;
  logic [7:0] tx_data = 8'h00, f_tx = 8'h00, rx_data, f_got;
  logic       sck_o, sck_oeb, mosi_o, mosi_oeb, miso_o, miso_oeb, tx_ready;
  logic       rx_valid, wake, sck_w, mosi_w, miso_w, f_sck, f_mosi, f_miso;
  logic       f_sel;
  int         mismatches = 0, compares = 0, cycles = 0;
  // role, rest level, phase, device word, far word
  spiwk_row_s rows [8] = '{
    '{1'b1, 1'b0, 1'b0, 8'hA5, 8'h3C},
    '{1'b1, 1'b0, 1'b1, 8'h81, 8'h7E},
    '{1'b1, 1'b1, 1'b0, 8'h01, 8'hFF},
    '{1'b1, 1'b1, 1'b1, 8'hFE, 8'h80},
    '{1'b0, 1'b0, 1'b0, 8'h96, 8'h69},
    '{1'b0, 1'b0, 1'b1, 8'h0F, 8'hF0},
    '{1'b0, 1'b1, 1'b0, 8'hC3, 8'h18},
    '{1'b0, 1'b1, 1'b1, 8'h7F, 8'h01}
  };
  // unselected select lines are pulled to the inactive level
  assign sck_w  = sck_oeb ? f_sck : sck_o;
  assign mosi_w = mosi_oeb ? f_mosi : mosi_o;
  assign miso_w = miso_oeb ? f_miso : miso_o;
  assign sel_w  = (sel_oeb & {3'h7, f_sel}) | (~sel_oeb & sel_o);
  initial forever #2 clk = ~clk;
  spiwk_top DUT (
    .ref_clk_in(clk), .rst_b_in(rst_b), .port_enable_in(en),
    .role_master_in(mst), .clock_capture_phase_select_in(pha),
    .clock_rest_level_select_in(pol), .sel_active_high_in(sel_hi),
    .sel_target_in(4'h1), .int_enable_set_in(ie_set),
    .int_enable_clr_in(ie_clr), .status_clr_in(st_clr),
    .tx_valid_in(tx_valid), .tx_data_in(tx_data), .rx_read_in(rx_read),
    .sck_in(sck_w), .mosi_in(mosi_w), .miso_in(miso_w), .sel_in(sel_w),
    .sck_out(sck_o), .sck_oe_b_out(sck_oeb), .mosi_out(mosi_o),
    .mosi_oe_b_out(mosi_oeb), .miso_out(miso_o), .miso_oe_b_out(miso_oeb),
    .sel_out(sel_o), .sel_oe_b_out(sel_oeb), .tx_ready_out(tx_ready),
    .rx_valid_out(rx_valid), .rx_data_out(rx_data), .status_out(status),
    .interrupt_enable_set_reg_out(ie_reg), .wake_out(wake));
  spiwk_far_model far (
    .master_in(!mst), .pol_in(pol), .pha_in(pha), .reply_in(f_tx),
    .sck_in(sck_w), .mosi_in(mosi_w), .miso_in(miso_w), .sel_in(sel_w[0]),
    .sck_out(f_sck), .mosi_out(f_mosi), .miso_out(f_miso), .sel_out(f_sel),
    .got_out(f_got));
  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_rx();
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    `CHK(rx_valid, 1'b1);
  endtask
  task automatic wait_check_wake(input logic exp);
    repeat (3) @(negedge clk);
    `CHK(wake, exp);
  endtask
  // run is a few thousand cycles, so this only trips on a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    `CHK(sel_o, 4'hF);
    `CHK({sck_oeb, mosi_oeb, miso_oeb}, 3'h7);
    @(posedge clk);
    rst_b <= 1'b1;
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      en      <= 1'b0;
      mst     <= rows[i].m;
      pol     <= rows[i].p;
      pha     <= rows[i].h;
      tx_data <= rows[i].tx;
      f_tx    <= rows[i].ftx;
      repeat (2) @(posedge clk);
      en <= 1'b1;
      repeat (20) @(posedge clk);
      if (rows[i].m) begin
        tx_valid <= 1'b1;
        do @(negedge clk); while (tx_ready !== 1'b0);
        @(posedge clk);
        tx_valid <= 1'b0;
        @(negedge clk);
        `CHK(sel_o, 4'hE);
        `CHK(sck_o, rows[i].p);
      end else begin
        far.master_frame();
      end
      wait_rx();
      // let the deselect pass the synchroniser before pin checks
      repeat (6) @(negedge clk);
      `CHK(rx_data, rows[i].ftx);
      `CHK(f_got, rows[i].tx);
      `CHK(sel_w[0], 1'b1);
      `CHK(sck_w, rows[i].p);
      `CHK(miso_oeb, 1'b1);
      `CHK(sck_oeb, ~rows[i].m);
      @(posedge clk);
      rx_read <= 1'b1;
      @(posedge clk);
      rx_read <= 1'b0;
      $display("test row %0d done", i);
    end
    // ****************
    // wake and overrun, slave role
    // ****************
    @(posedge clk);
    mst    <= 1'b0;
    pol    <= 1'b0;
    pha    <= 1'b0;
    st_clr <= 3'h7;
    ie_set <= 3'h1;
    f_tx   <= 8'h5A;
    @(posedge clk);
    st_clr <= 3'h0;
    ie_set <= 3'h0;
    far.master_frame();
    wait_rx();
    `CHK(status, 3'h5);
    `CHK(ie_reg, 3'h1);
    wait_check_wake(1'b1);
    @(posedge clk);
    f_tx <= 8'hC3;
    far.master_frame();
    @(negedge clk);
    `CHK(status[1], 1'b1);
    `CHK(rx_data, 8'h5A);
    @(posedge clk);
    ie_clr <= 3'h1;
    @(posedge clk);
    ie_clr <= 3'h0;
    wait_check_wake(1'b0);
    @(posedge clk);
    ie_set <= 3'h2;
    @(posedge clk);
    ie_set <= 3'h0;
    wait_check_wake(1'b1);
    @(posedge clk);
    st_clr  <= 3'h7;
    rx_read <= 1'b1;
    @(posedge clk);
    st_clr  <= 3'h0;
    rx_read <= 1'b0;
    wait_check_wake(1'b0);
    @(posedge clk);
    ie_clr <= 3'h7;
    @(posedge clk);
    ie_clr <= 3'h0;
    $display("test wake done");
    // ****************
    // disabled port
    // ****************
    @(posedge clk);
    en       <= 1'b0;
    mst      <= 1'b1;
    tx_valid <= 1'b1;
    repeat (40) @(negedge clk);
    `CHK({sck_oeb, mosi_oeb, sel_oeb}, 6'h00);
    `CHK({miso_oeb, tx_ready, rx_valid}, 3'h4);
    `CHK(sck_o, 1'b0);
    @(posedge clk);
    tx_valid <= 1'b0;
    mst      <= 1'b0;
    repeat (4) @(negedge clk);
    `CHK({sck_oeb, miso_oeb}, 2'h3);
    $display("test disabled done");
    @(posedge clk);
    en     <= 1'b1;
    mst    <= 1'b1;
    sel_hi <= 4'h1;
    repeat (4) @(negedge clk);
    `CHK(sel_o, 4'hE);
    $display("test polarity done");
    give_verdict();
  end
endmodule
`default_nettype wire
